// file: common/i2c_recovery_defines.svh
// Constants of the I2C wiper target: addresses, command fields, wiper values
// Assumes inclusion by bare name ahead of any module that uses them
`ifndef I2C_RECOVERY_DEFINES_SVH
`define I2C_RECOVERY_DEFINES_SVH
`define TARGET_ADDR_DEFAULT 7'h2C
`define GC_ADDR 7'h00
`define MEM_WIPER0 4'h0
`define MEM_WIPER1 4'h1
`define MEM_WIPER2 4'h6
`define MEM_WIPER3 4'h7
`define MEM_NV0 4'h2
`define MEM_NV1 4'h3
`define MEM_NV2 4'h8
`define MEM_NV3 4'h9
`define CMD_ADDR_MSB 7
`define CMD_ADDR_LSB 4
`define CMD_OP_MSB 3
`define CMD_OP_LSB 2
`define CMD_D8_BIT 0
`define WIPER_RESET 9'h080
`define WIPER_FULL 9'h100
`define WIPER_ZERO 9'h000
`define WIPER_STEP 9'h001
`define BYTE_BITS 4'h8
`define LAST_BIT 4'h7
`endif

// file: common/i2c_recovery_pkg.sv
// Types shared by the wiper target and its line synchroniser
// Assumes the constants header is compiled alongside
`default_nettype none
package i2c_recovery_pkg;
   typedef logic [8:0] wiper_t;
   typedef enum logic [1:0] {op_write, op_inc, op_dec, op_read} cmd_op_e;
   typedef enum logic [2:0] {rq_write, rq_inc, rq_dec, rq_read, rq_nv} req_e;
   typedef enum logic [2:0] {st_idle, st_addr, st_cmd, st_data, st_ack, st_tx, st_tack, st_tnext} link_st_e;
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic prev;
   } sync_s;
   typedef struct packed {
      link_st_e st;
      link_st_e after;
      logic [7:0] bits;
      logic [3:0] cnt;
      logic gc;
      logic [7:0] cmd;
      logic do_act;
      logic [1:0] ptr;
      logic [7:0] tx;
      logic tx_lo;
      logic pend_nv;
      logic [1:0] nv_sel;
      wiper_t nv_val;
      logic req_tgl;
      req_e req_op;
      logic [1:0] req_idx;
      wiper_t req_val;
      logic busy;
      wiper_t rd_val;
      logic sda_oe;
   } link_s;
   typedef struct packed {
      logic ack_tgl;
      wiper_t [3:0] wiper;
      wiper_t rd_val;
      logic nv_go;
      logic [1:0] nv_sel;
      wiper_t nv_val;
   } core_s;
endpackage
`default_nettype wire

// file: common/sync_line_if.sv
// One line brought into a clock domain: raw value in, agreed level and edges out
// Assumes the filter side is a sync_agree instance
`timescale 1ns/1ps
`default_nettype none
interface sync_line_if;
   logic raw;
   logic level;
   logic rise;
   logic fall;
   modport filter (input raw, output level, output rise, output fall);
   modport user (output raw, input level, input rise, input fall);
endinterface
`default_nettype wire

// file: hw/i2c_target_reset_recovery.sv
// I2C target for a bank of four wipers with bus recovery and general-call update
// Assumes SDA is resolved open-drain outside, SCL is input only, no clock stretching
`timescale 1ns/1ps
`default_nettype none
`include "i2c_recovery_defines.svh"
// Functional notes
// [R1] Start while receiving restarts serial machine
// [R2] Master recovers: Start, nine ones, Start, Stop
// [R3] High at acknowledge slot means reset interface
// [R4] Recovery touches serial machine only, nothing else
// [R5] Start during write acknowledge cancels pending write
// [R6] After Stop ignore bus until Start
// [R7] General call accepts write, increment, decrement
// [R8] Non-participants belong on separate bus segment
// [R9] Nonvolatile write only after full command, Stop
// [R10] Start and Stop detected at any bit
module i2c_target_reset_recovery
   import i2c_recovery_pkg::*;
#(
   parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR_DEFAULT
)
(
   // System domain
   input wire logic clk,
   input wire logic reset,
   // Link domain
   input wire logic link_clk,
   // I2C pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Serial machine waiting for a Start
   output logic serial_idle,
   // Wiper settings
   output var wiper_t [3:0] wiper,
   // Nonvolatile write request
   output logic nv_write,
   output logic [1:0] nv_sel,
   output var wiper_t nv_value
);
   sync_line_if rst_l ();
   sync_line_if scl_l ();
   sync_line_if sda_l ();
   sync_line_if req_l ();
   sync_line_if ack_l ();
   logic link_rst;
   link_s lq;
   link_s ln;
   core_s cq;
   core_s cn;

   assign rst_l.raw = reset;
   assign scl_l.raw = scl_in;
   assign sda_l.raw = sda_in;
   assign req_l.raw = lq.req_tgl;
   assign ack_l.raw = cq.ack_tgl;
   assign link_rst = rst_l.level;

   // Reset reaches the link domain through its own synchroniser
   sync_agree #(.INIT(1'b1)) rst_sync (
      .clk(link_clk),
      .reset(1'b0),
      .line(rst_l)
   );
   sync_agree #(.INIT(1'b1)) scl_sync (
      .clk(link_clk),
      .reset(link_rst),
      .line(scl_l)
   );
   sync_agree #(.INIT(1'b1)) sda_sync (
      .clk(link_clk),
      .reset(link_rst),
      .line(sda_l)
   );
   sync_agree #(.INIT(1'b0)) ack_sync (
      .clk(link_clk),
      .reset(link_rst),
      .line(ack_l)
   );
   sync_agree #(.INIT(1'b0)) req_sync (
      .clk(clk),
      .reset(reset),
      .line(req_l)
   );

   function automatic logic [2:0] vol_map(input logic [3:0] a);
      case (a)
         `MEM_WIPER0: vol_map = 3'h4;
         `MEM_WIPER1: vol_map = 3'h5;
         `MEM_WIPER2: vol_map = 3'h6;
         `MEM_WIPER3: vol_map = 3'h7;
         default: vol_map = 3'h0;
      endcase
   endfunction

   function automatic logic [2:0] nv_map(input logic [3:0] a);
      case (a)
         `MEM_NV0: nv_map = 3'h4;
         `MEM_NV1: nv_map = 3'h5;
         `MEM_NV2: nv_map = 3'h6;
         `MEM_NV3: nv_map = 3'h7;
         default: nv_map = 3'h0;
      endcase
   endfunction

   // High byte carries only the ninth wiper bit
   function automatic logic [7:0] tx_byte(input logic lo, input wiper_t v);
      tx_byte = lo ? v[7:0] : {7'h00, v[8]};
   endfunction

   function automatic wiper_t clamp(input wiper_t v);
      clamp = (v > `WIPER_FULL) ? `WIPER_FULL : v;
   endfunction

   always_comb begin
      logic start;
      logic stop;
      logic go;
      logic nack;
      req_e gop;
      logic [1:0] gidx;
      wiper_t gval;
      logic [2:0] vm;
      logic [2:0] nm;
      logic [2:0] dvm;
      logic [2:0] dnm;
      cmd_op_e cop;
      start = scl_l.level & sda_l.fall;
      stop = scl_l.level & sda_l.rise;
      go = 1'b0;
      nack = 1'b0;
      gop = rq_write;
      gidx = 2'h0;
      gval = `WIPER_ZERO;
      vm = vol_map(lq.bits[`CMD_ADDR_MSB:`CMD_ADDR_LSB]);
      nm = nv_map(lq.bits[`CMD_ADDR_MSB:`CMD_ADDR_LSB]);
      dvm = vol_map(lq.cmd[`CMD_ADDR_MSB:`CMD_ADDR_LSB]);
      dnm = nv_map(lq.cmd[`CMD_ADDR_MSB:`CMD_ADDR_LSB]);
      cop = cmd_op_e'(lq.bits[`CMD_OP_MSB:`CMD_OP_LSB]);
      ln = lq;
      if (ack_l.rise | ack_l.fall) begin
         ln.busy = 1'b0;
         ln.rd_val = cq.rd_val;
      end
      // Bus conditions take priority over every state and bit count  see [R10]
      if (start) begin
         // Wipers live in the core domain and are left alone  see [R4]
         ln.st = st_addr; // see [R1]
         ln.cnt = 4'h0;
         ln.sda_oe = 1'b0;
         ln.do_act = 1'b0;
         ln.pend_nv = 1'b0; // see [R5]
      end else if (stop) begin
         if (lq.pend_nv) begin
            go = 1'b1; // see [R9]
            gop = rq_nv;
            gidx = lq.nv_sel;
            gval = lq.nv_val;
         end
         ln.pend_nv = 1'b0;
         ln.do_act = 1'b0;
         ln.sda_oe = 1'b0;
         ln.st = st_idle; // see [R6]
      end else begin
         case (lq.st)
            st_idle: begin
               ln.st = st_idle; // see [R6]
            end
            st_addr, st_cmd, st_data: begin
               if (scl_l.rise && lq.cnt != `BYTE_BITS) begin
                  ln.bits = {lq.bits[6:0], sda_l.level};
                  ln.cnt = lq.cnt + 4'h1;
               end
               if (scl_l.fall && lq.cnt == `BYTE_BITS) begin
                  ln.cnt = 4'h0;
                  ln.st = st_ack;
                  ln.sda_oe = 1'b1;
                  ln.after = st_cmd;
                  case (lq.st)
                     st_addr: begin
                        if (lq.bits[7:1] == TARGET_ADDR) begin
                           ln.gc = 1'b0;
                           ln.tx_lo = 1'b0;
                           if (lq.bits[0]) begin
                              ln.after = st_tx;
                              go = 1'b1;
                              gop = rq_read;
                              gidx = lq.ptr;
                           end
                        end else if (lq.bits == {`GC_ADDR, 1'b0}) begin
                           // Every listening target takes the same command  see [R7] [R8]
                           ln.gc = 1'b1;
                        end else begin
                           nack = 1'b1;
                        end
                     end
                     st_cmd: begin
                        ln.cmd = lq.bits;
                        case (cop)
                           op_write: begin
                              if (vm[2] || (nm[2] && !lq.gc)) begin
                                 ln.after = st_data;
                              end else begin
                                 nack = 1'b1;
                              end
                           end
                           op_inc, op_dec: begin
                              if (vm[2]) begin
                                 ln.do_act = 1'b1; // see [R7]
                              end else begin
                                 nack = 1'b1;
                              end
                           end
                           op_read: begin
                              if (vm[2] && !lq.gc) begin
                                 ln.ptr = vm[1:0];
                              end else begin
                                 nack = 1'b1;
                              end
                           end
                           default: begin
                              nack = 1'b1;
                           end
                        endcase
                     end
                     default: begin
                        if (dvm[2]) begin
                           ln.do_act = 1'b1;
                        end else begin
                           // Held until Stop; a Start in between drops it  see [R9]
                           ln.pend_nv = 1'b1;
                           ln.nv_sel = dnm[1:0];
                           ln.nv_val = clamp({lq.cmd[`CMD_D8_BIT], lq.bits});
                        end
                     end
                  endcase
                  if (nack) begin
                     ln.st = st_idle;
                     ln.sda_oe = 1'b0;
                  end
               end
            end
            st_ack: begin
               if (scl_l.rise && sda_l.level) begin
                  // Line high while driving low: treat as not-acknowledge  see [R3]
                  ln.st = st_idle;
                  ln.sda_oe = 1'b0;
                  ln.do_act = 1'b0;
                  ln.pend_nv = 1'b0;
               end else if (scl_l.fall) begin
                  ln.sda_oe = 1'b0;
                  ln.st = lq.after;
                  ln.do_act = 1'b0;
                  if (lq.do_act) begin
                     go = 1'b1;
                     gop = req_e'({1'b0, lq.cmd[`CMD_OP_MSB:`CMD_OP_LSB]});
                     gidx = dvm[1:0];
                     gval = clamp({lq.cmd[`CMD_D8_BIT], lq.bits});
                  end
                  if (lq.after == st_tx) begin
                     ln.tx = tx_byte(lq.tx_lo, lq.rd_val);
                     ln.tx_lo = ~lq.tx_lo;
                     ln.sda_oe = ~ln.tx[7];
                  end
               end
            end
            st_tx: begin
               if (scl_l.fall) begin
                  if (lq.cnt == `LAST_BIT) begin
                     ln.cnt = 4'h0;
                     ln.sda_oe = 1'b0;
                     ln.st = st_tack;
                  end else begin
                     ln.cnt = lq.cnt + 4'h1;
                     ln.tx = {lq.tx[6:0], 1'b0};
                     ln.sda_oe = ~ln.tx[7];
                  end
               end
            end
            st_tack: begin
               if (scl_l.rise) begin
                  ln.st = sda_l.level ? st_idle : st_tnext; // see [R3]
               end
            end
            st_tnext: begin
               if (scl_l.fall) begin
                  ln.st = st_tx;
                  ln.tx = tx_byte(lq.tx_lo, lq.rd_val);
                  ln.tx_lo = ~lq.tx_lo;
                  ln.sda_oe = ~ln.tx[7];
               end
            end
            default: begin
               ln.st = st_idle;
               ln.sda_oe = 1'b0;
            end
         endcase
      end
      // One request in flight; a second one while busy is lost
      if (go && !ln.busy) begin
         ln.req_tgl = ~lq.req_tgl;
         ln.req_op = gop;
         ln.req_idx = gidx;
         ln.req_val = gval;
         ln.busy = 1'b1;
      end
   end

   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         lq <= '0;
      end else begin
         lq <= ln;
      end
   end

   // Request fields stay still from toggle to acknowledge, so they cross as held words
   always_comb begin
      cn = cq;
      cn.nv_go = 1'b0;
      if (req_l.rise | req_l.fall) begin
         cn.ack_tgl = ~cq.ack_tgl;
         case (lq.req_op)
            rq_write: begin
               cn.wiper[lq.req_idx] = lq.req_val;
            end
            rq_inc: begin
               if (cq.wiper[lq.req_idx] < `WIPER_FULL) begin
                  cn.wiper[lq.req_idx] = cq.wiper[lq.req_idx] + `WIPER_STEP;
               end
            end
            rq_dec: begin
               if (cq.wiper[lq.req_idx] != `WIPER_ZERO && cq.wiper[lq.req_idx] <= `WIPER_FULL) begin
                  cn.wiper[lq.req_idx] = cq.wiper[lq.req_idx] - `WIPER_STEP;
               end
            end
            rq_read: begin
               cn.rd_val = cq.wiper[lq.req_idx];
            end
            rq_nv: begin
               cn.nv_go = 1'b1; // see [R9]
               cn.nv_sel = lq.req_idx;
               cn.nv_val = lq.req_val;
            end
            default: begin
               cn.ack_tgl = ~cq.ack_tgl;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cq <= '{ack_tgl: 1'b0, wiper: {4{`WIPER_RESET}}, rd_val: `WIPER_RESET,
                 nv_go: 1'b0, nv_sel: 2'h0, nv_val: `WIPER_ZERO};
      end else begin
         cq <= cn;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = lq.sda_oe;
   assign serial_idle = (lq.st == st_idle);
   assign wiper = cq.wiper;
   assign nv_write = cq.nv_go;
   assign nv_sel = cq.nv_sel;
   assign nv_value = cq.nv_val;
endmodule
`default_nettype wire

// file: hw/sync_agree.sv
// Three-stage synchroniser whose level moves only when stages two and three agree
// Assumes the raw line is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module sync_agree
   import i2c_recovery_pkg::*;
#(
   parameter logic INIT = 1'b0
)
(
   // Receiving domain
   input wire logic clk,
   input wire logic reset,
   // Line
   sync_line_if.filter line
);
   sync_s q;
   sync_s n;

   always_comb begin
      n = q;
      n.s1 = line.raw;
      n.s2 = q.s1;
      n.s3 = q.s2;
      // Stage one feeds stage two only, never the compare
      if (q.s2 == q.s3) begin
         n.level = q.s3;
      end
      n.prev = q.level;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= {5{INIT}};
      end else begin
         q <= n;
      end
   end

   assign line.level = q.level;
   assign line.rise = q.level & ~q.prev;
   assign line.fall = ~q.level & q.prev;
endmodule
`default_nettype wire

// file: verification/i2c_master_model.sv
// Bus master model: Start, Stop, bit and byte transfers, recovery sequence
// Assumes an open-drain data wire resolved outside with a pull-up
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
   parameter int QUARTER = 20
)
(
   // Timing reference
   input wire logic clk,
   // Resolved data wire
   input wire logic sda_wire,
   // Driven lines, data released when high
   output logic scl,
   output logic sda_drv
);
   // Sole master and sole target on this segment
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic qw();
      repeat (QUARTER) @(negedge clk);
   endtask
   task automatic start();
      sda_drv = 1'b1;
      qw();
      scl = 1'b1;
      qw();
      sda_drv = 1'b0;
      qw();
      scl = 1'b0;
      qw();
   endtask
   task automatic stop();
      sda_drv = 1'b0;
      qw();
      scl = 1'b1;
      qw();
      sda_drv = 1'b1;
      qw();
      qw();
   endtask
   // Data moves only in the low phase
   task automatic bit_x(input logic b, output logic r);
      sda_drv = b;
      qw();
      scl = 1'b1;
      qw();
      r = sda_wire;
      qw();
      scl = 1'b0;
      qw();
   endtask
   task automatic wbits(input logic [7:0] d, input int n);
      logic r;
      for (int i = 0; i < n; i++) bit_x(d[7 - i], r);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      wbits(d, 8);
      bit_x(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(nack, r);
   endtask
   task automatic recover();
      logic r;
      start();
      for (int i = 0; i < 9; i++) bit_x(1'b1, r);
      start();
      stop();
   endtask
endmodule
`default_nettype wire

// file: verification/i2c_target_reset_recovery_sva.sv
// Checker of the wiper target's pin, wiper and nonvolatile output timing
// Assumes it is bound to the target and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module i2c_target_reset_recovery_sva
   import i2c_recovery_pkg::*;
(
   // Clocks and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic link_clk,
   // Pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic serial_idle,
   // Outputs
   input wire wiper_t [3:0] wiper,
   input wire logic nv_write,
   input wire logic [1:0] nv_sel,
   input wire wiper_t nv_value
);
   sequence stop_seen;
      scl_in && !sda_in ##1 scl_in && sda_in;
   endsequence
   sequence idle_held;
      serial_idle [*2];
   endsequence
   a_stop_idle: assert property (@(posedge link_clk) disable iff (reset) stop_seen |-> ##[1:8] serial_idle)
      else $error("serial machine not idle after stop");
   a_idle_quiet: assert property (@(posedge link_clk) disable iff (reset) idle_held |-> !sda_oe)
      else $error("data line driven while idle");
   // Pin moves only in the low phase, so no false Start or Stop
   a_oe_scl_low: assert property (@(posedge link_clk) disable iff (reset) $changed(sda_oe) |-> !scl_in)
      else $error("data drive changed while clock high");
   a_open_drain: assert property (@(posedge clk) disable iff (reset) sda_out == 1'b0)
      else $error("data output not low");
   a_nv_pulse: assert property (@(posedge clk) disable iff (reset) nv_write |=> !nv_write)
      else $error("nonvolatile request longer than one cycle");
   a_nv_hold: assert property (@(posedge clk) disable iff (reset)
      !nv_write |-> $stable(nv_sel) && $stable(nv_value))
      else $error("nonvolatile selection moved without request");
   // A commit can only follow a Stop, when the bus rests high
   a_nv_bus_idle: assert property (@(posedge clk) disable iff (reset) nv_write |-> scl_in && sda_in)
      else $error("nonvolatile write outside idle bus");
   a_wiper_scl_low: assert property (@(posedge clk) disable iff (reset) $changed(wiper) |-> !scl_in)
      else $error("wiper changed during start or stop");
   a_wiper_range: assert property (@(posedge clk) disable iff (reset)
      wiper[0] <= 9'h100 && wiper[1] <= 9'h100 && wiper[2] <= 9'h100 && wiper[3] <= 9'h100)
      else $error("wiper above full scale");
endmodule
bind i2c_target_reset_recovery i2c_target_reset_recovery_sva u_sva (.clk(clk), .reset(reset),
   .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .serial_idle(serial_idle), .wiper(wiper), .nv_write(nv_write), .nv_sel(nv_sel), .nv_value(nv_value));
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench of the wiper target driven by the bus master model
// Assumes the model drives SCL and releases SDA to a pull-up
`timescale 1ns/1ps
`default_nettype none
module tb;
   import i2c_recovery_pkg::*;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset = 1'b1;
   logic scl_in, sda_drv, sda_in, sda_out, sda_oe, serial_idle, nv_write;
   logic [1:0] nv_sel;
   wiper_t [3:0] wiper;
   wiper_t nv_value;
   wiper_t exp_w [4] = '{9'h080, 9'h080, 9'h080, 9'h080};
   int err_count = 0;
   int checks = 0;
   int nv_count = 0;
   assign sda_in = sda_drv & !(sda_oe === 1'b1 && sda_out === 1'b0);
   always #12.5 clk = ~clk;
   initial begin
      #7;
      forever #24 link_clk = ~link_clk;
   end
   always @(posedge clk) if (nv_write === 1'b1) nv_count++;
   i2c_target_reset_recovery u_i2c_target_reset_recovery (.clk(clk), .reset(reset), .link_clk(link_clk),
      .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .serial_idle(serial_idle),
      .wiper(wiper), .nv_write(nv_write), .nv_sel(nv_sel), .nv_value(nv_value));
   i2c_master_model u_i2c_master_model (.clk(clk), .sda_wire(sda_in), .scl(scl_in), .sda_drv(sda_drv));
   task automatic results();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cb(input string name, input logic exp, input logic got);
      chk(name, {8'h00, exp}, {8'h00, got});
   endtask
   task automatic chk_w();
      for (int i = 0; i < 4; i++) chk("wiper", exp_w[i], wiper[i]);
   endtask
   task automatic wbs(input logic [31:0] d, input int n, input logic exp);
      logic a;
      for (int i = n - 1; i >= 0; i--) begin
         u_i2c_master_model.wbyte(d[8 * i +: 8], a);
         cb("ack", exp, a);
      end
   endtask
   task automatic st();
      u_i2c_master_model.start();
   endtask
   task automatic sp();
      u_i2c_master_model.stop();
   endtask
   task automatic t_reset();
      chk_w();
      cb("idle", 1'b1, serial_idle);
      cb("drive", 1'b0, sda_oe);
   endtask
   task automatic t_write();
      logic [7:0] d;
      st();
      wbs(32'h581033, 3, 1'b1);
      sp();
      exp_w[1] = 9'h033;
      chk_w();
      cb("idle", 1'b1, serial_idle);
      st();
      wbs(32'h581C, 2, 1'b1);
      st();
      wbs(32'h59, 1, 1'b1);
      u_i2c_master_model.rbyte(1'b0, d);
      chk("read high", 9'h000, {1'b0, d});
      u_i2c_master_model.rbyte(1'b1, d);
      chk("read low", 9'h033, {1'b0, d});
      sp();
      cb("idle", 1'b1, serial_idle);
   endtask
   task automatic t_abort();
      st();
      wbs(32'h58, 1, 1'b1);
      u_i2c_master_model.wbits(8'h60, 4);
      st();
      wbs(32'h587055, 3, 1'b1);
      sp();
      exp_w[3] = 9'h055;
      chk_w();
   endtask
   task automatic t_gc();
      st();
      wbs(32'h00041870, 4, 1'b1);
      wbs(32'hFF6120, 3, 1'b1);
      sp();
      exp_w[0] = 9'h081;
      exp_w[1] = 9'h032;
      exp_w[2] = 9'h100;
      exp_w[3] = 9'h0FF;
      chk_w();
      st();
      wbs(32'h00, 1, 1'b1);
      wbs(32'h20, 1, 1'b0);
      sp();
      chk("nv count", 9'h000, 9'(nv_count));
   endtask
   task automatic t_nv();
      st();
      wbs(32'h582044, 3, 1'b1);
      sp();
      chk("nv count", 9'h001, 9'(nv_count));
      chk("nv sel", 9'h000, {7'h00, nv_sel});
      chk("nv value", 9'h044, nv_value);
      st();
      wbs(32'h583122, 3, 1'b1);
      st();
      sp();
      chk("nv count", 9'h001, 9'(nv_count));
      st();
      wbs(32'h5830, 2, 1'b1);
      u_i2c_master_model.wbits(8'hAA, 5);
      sp();
      chk("nv count", 9'h001, 9'(nv_count));
      cb("idle", 1'b1, serial_idle);
   endtask
   task automatic t_recover();
      logic b;
      st();
      wbs(32'h580C, 2, 1'b1);
      st();
      wbs(32'h59, 1, 1'b1);
      for (int i = 0; i < 3; i++) u_i2c_master_model.bit_x(1'b1, b);
      cb("drive", 1'b1, sda_oe);
      u_i2c_master_model.recover();
      cb("idle", 1'b1, serial_idle);
      chk_w();
      chk("nv count", 9'h001, 9'(nv_count));
      st();
      wbs(32'h580012, 3, 1'b1);
      sp();
      exp_w[0] = 9'h012;
      chk_w();
   endtask
   task automatic t_ignore();
      logic b;
      u_i2c_master_model.bit_x(1'b1, b);
      wbs(32'h581077, 3, 1'b0);
      sp();
      chk_w();
      st();
      wbs(32'h5A1066, 3, 1'b0);
      sp();
      chk_w();
   endtask
   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      repeat (30) @(negedge clk);
      t_reset();
      t_write();
      t_abort();
      t_gc();
      t_nv();
      t_recover();
      t_ignore();
      results();
   end
   // Run needs about 34000 cycles
   initial begin
      repeat (80000) @(posedge clk);
      err_count++;
      results();
   end
endmodule
`default_nettype wire
